// ---- design/feat_regs.sv ----
// Feature-enable register bank behind an AHB-Lite slave, with prefetch engine.
// Assumes single word transfers; the slave answers with zero wait states.
`timescale 1ns/1ns
module feat_regs
   import feat_pkg::*;
#(
   parameter int AW = 32,
   parameter bit ACCEL_SUPPORTED = 1'b1
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic load_valid,
   input wire logic [AW-1:0] load_addr,
   output logic pf_valid,
   output logic [AW-1:0] pf_addr,
   output logic scale_enable,
   output logic scale_locked,
   output logic accel_enabled_flag
);
   typedef struct packed {
      logic wr_pend;
      logic [7:0] addr;
      logic scale_en;
      logic lock;
      logic nl_dis;
      logic sh_dis;
      logic accel_dis;
      logic [31:0] rdata;
   } reg_state_t;
   reg_state_t s_q, s_d;
   logic [63:0] image;
   logic [31:0] word;
   logic nl_active;
   logic sh_active;
   logic addr_ok;

   pf_engine #(.AW(AW)) u_pf (
      .clock(clock),
      .resetn(resetn),
      .nl_disable(s_q.nl_dis),
      .sh_disable(s_q.sh_dis),
      .load_valid(load_valid),
      .load_addr(load_addr),
      .pf_valid(pf_valid),
      .pf_addr(pf_addr),
      .nl_active(nl_active),
      .sh_active(sh_active)
   );

   // ==========================================================
   // Register image; unlisted bits stay zero.
   always_comb begin
      image = '0;
      image[BIT_SCALE_EN] = s_q.scale_en;
      image[BIT_SCALE_LOCK] = s_q.lock;
      image[BIT_NL_DIS] = s_q.nl_dis;
      image[BIT_ACCEL_DIS] = s_q.accel_dis;
      image[BIT_SH_DIS] = s_q.sh_dis;
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign scale_enable = s_q.scale_en;
   assign scale_locked = s_q.lock;
   assign accel_enabled_flag = ACCEL_SUPPORTED && !s_q.accel_dis;
   assign addr_ok = haddr[1:0] == 2'b00;
   assign word = hwdata;

   // ==========================================================
   // Bus slave
   always_comb begin
      logic [63:0] wimg;
      wimg = image;
      s_d = s_q;
      s_d.wr_pend = 1'b0;
      if (s_q.wr_pend) begin
         if (s_q.addr == OFS_LOW) begin
            wimg[31:0] = word;
         end else if (s_q.addr == OFS_HIGH) begin
            wimg[63:32] = word;
         end
         if (s_q.addr == OFS_LOW || s_q.addr == OFS_HIGH) begin
            wimg = wimg & WRITABLE_MASK;
            if (!s_q.lock) begin
               s_d.scale_en = wimg[BIT_SCALE_EN];
               s_d.lock = wimg[BIT_SCALE_LOCK];
            end
            s_d.nl_dis = wimg[BIT_NL_DIS];
            s_d.sh_dis = wimg[BIT_SH_DIS];
            s_d.accel_dis = ACCEL_SUPPORTED ? wimg[BIT_ACCEL_DIS] : 1'b0;
         end
      end
      if (hsel && hready && htrans[1] && addr_ok) begin
         s_d.wr_pend = hwrite;
         s_d.addr = haddr[7:0];
         s_d.rdata = 32'h0000_0000;
         if (!hwrite) begin
            unique case (haddr[7:0])
               OFS_LOW: s_d.rdata = image[31:0];
               OFS_HIGH: s_d.rdata = image[63:32];
               OFS_QUERY: s_d.rdata = 32'({accel_enabled_flag, 1'b0});
               OFS_PF_STATUS: s_d.rdata = {30'h0000_0000, sh_active, nl_active};
               default: s_d.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.accel_dis <= ACCEL_SUPPORTED;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- design/feat_pkg.sv ----
// Constants for the feature-enable register bank and its prefetch monitors.
// Assumes a single 125 MHz clock and an AHB-Lite slave with 32-bit data.
// Overview of operation
// - Once the lock is one, the lock and scaling enable ignore writes.
// - Reset clears the lock, making the locked bits writable again.
// - Next-line disable bit one turns that prefetcher off; resets to zero.
// - Next-line prefetcher watches repeated loads to one line within a time limit.
// - On detection it fetches the following line from L2 or memory.
// - Writing acceleration disable one disables it; query leaf bit 1 reads zero.
// - While acceleration disable is zero on supported hardware, query leaf bit 1 reports enabled.
// - Power-on value of acceleration disable shows hardware support: one present.
// - Sequential-history disable bit one turns that prefetcher off; resets zero.
// - Sequential-history prefetcher uses sequential load history to prefetch next data.
// - Scaling enable sits at bit 16 and is read/write while unlocked.
package feat_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] OFS_LOW = 8'h00;
   localparam logic [7:0] OFS_HIGH = 8'h04;
   localparam logic [7:0] OFS_QUERY = 8'h08;
   localparam logic [7:0] OFS_PF_STATUS = 8'h0C;
   // ==========================================================
   // Field positions within the 64-bit register and the query word
   localparam int BIT_SCALE_EN = 16;
   localparam int BIT_SCALE_LOCK = 20;
   localparam int BIT_NL_DIS = 37;
   localparam int BIT_ACCEL_DIS = 38;
   localparam int BIT_SH_DIS = 39;
   localparam int BIT_ACCEL_FLAG = 1;
   localparam logic [63:0] WRITABLE_MASK = 64'h0000_00E0_0011_0000;
   // ==========================================================
   // Prefetch timing
   localparam int WINDOW_NS = 64;
   localparam int CLOCK_NS = 8;
   localparam int WINDOW_CYC = WINDOW_NS / CLOCK_NS;
   localparam int NL_HITS = 3;
   localparam int LINE_LSB = 6;
endpackage

// ---- design/pf_engine.sv ----
// Prefetch decision logic for the next-line and sequential-history prefetchers.
// Assumes load addresses arrive as one-cycle valid pulses on the core clock.
`timescale 1ns/1ns
module pf_engine
   import feat_pkg::*;
#(
   parameter int AW = 32
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic nl_disable,
   input wire logic sh_disable,
   input wire logic load_valid,
   input wire logic [AW-1:0] load_addr,
   output logic pf_valid,
   output logic [AW-1:0] pf_addr,
   output logic nl_active,
   output logic sh_active
);
   typedef struct packed {
      logic [AW-1:0] line;
      logic [AW-1:0] prev_line;
      logic [3:0] hits;
      logic [7:0] age;
      logic pf_valid;
      logic [AW-1:0] pf_addr;
   } pf_state_t;
   pf_state_t s_q, s_d;
   logic [AW-1:0] cur_line;
   localparam logic [AW-1:0] ONE_LINE = AW'(1);

   assign cur_line = load_addr >> LINE_LSB;
   assign nl_active = !nl_disable;
   assign sh_active = !sh_disable;
   assign pf_valid = s_q.pf_valid;
   assign pf_addr = s_q.pf_addr;

   // ==========================================================
   // Detection
   always_comb begin
      s_d = s_q;
      s_d.pf_valid = 1'b0;
      if (s_q.age < 8'(WINDOW_CYC)) begin
         s_d.age = s_q.age + 8'h01;
      end else begin
         s_d.hits = 4'h0;
      end
      if (load_valid) begin
         if (cur_line == s_q.line && s_q.age < 8'(WINDOW_CYC)) begin
            s_d.hits = s_q.hits + 4'h1;
         end else begin
            s_d.hits = 4'h1;
            s_d.age = 8'h00;
         end
         s_d.line = cur_line;
         s_d.prev_line = cur_line;
         if (nl_active && cur_line == s_q.line && s_q.age < 8'(WINDOW_CYC)
             && s_q.hits + 4'h1 >= 4'(NL_HITS)) begin
            s_d.pf_valid = 1'b1;
            s_d.pf_addr = (cur_line + ONE_LINE) << LINE_LSB;
            s_d.hits = 4'h0;
         end else if (sh_active && cur_line == s_q.prev_line + ONE_LINE) begin
            s_d.pf_valid = 1'b1;
            s_d.pf_addr = (cur_line + ONE_LINE) << LINE_LSB;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- dv/feat_regs_chk.sv ----
// Checker for the feature register bank, bound to its top module.
// Assumes the bench keeps haddr inside the low byte of the map.
`timescale 1ns/1ns
module feat_regs_chk
   import feat_pkg::*;
#(parameter int AW = 32) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic load_valid,
   input wire logic [AW-1:0] load_addr,
   input wire logic pf_valid,
   input wire logic [AW-1:0] pf_addr,
   input wire logic scale_enable,
   input wire logic scale_locked,
   input wire logic accel_enabled_flag
);
   // ==========================================================
   // Data phase tracking.
   logic wr_q, rd_q, t;
   logic [7:0] a_q;
   assign t = hsel & hready & htrans[1];
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) {wr_q, rd_q, a_q} <= 10'h000;
      else {wr_q, rd_q, a_q} <= {{2{t}} & {hwrite, !hwrite}, haddr[7:0]};
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   ready_ok_a: assert property (hreadyout && !hresp) else $error("not ready or not okay");
   lock_sticky_a: assert property (scale_locked |=> scale_locked) else $error("lock fell");
   scale_hold_a: assert property (scale_locked |=> $stable(scale_enable)) else $error("moved");
   lock_reset_a: assert property (!$past(resetn) |-> !scale_locked) else $error("lock kept");
   scale_cause_a: assert property ($changed({scale_enable, scale_locked})
      |-> $past(wr_q && a_q == OFS_LOW)) else $error("scale bits changed unasked");
   accel_cause_a: assert property ($changed(accel_enabled_flag)
      |-> $past(wr_q && a_q == OFS_HIGH)) else $error("flag changed unasked");
   pf_cause_a: assert property (pf_valid |-> $past(load_valid)) else $error("stray fetch");
   pf_next_a: assert property (pf_valid |-> pf_addr ==
      {$past(load_addr[AW-1:LINE_LSB]) + 1'b1, {LINE_LSB{1'b0}}}) else $error("bad fetch line");
   rsv_high_a: assert property (rd_q && a_q == OFS_HIGH |->
      hrdata[31:8] == 24'h0 && hrdata[4:0] == 5'h0) else $error("reserved high bits set");
   rsv_low_a: assert property (rd_q && a_q == OFS_LOW |->
      (hrdata & 32'hFFEE_FFFF) == 32'h0) else $error("reserved low bits set");
   cover property ($rose(scale_locked));
   cover property (pf_valid);
   cover property ($fell(accel_enabled_flag));
endmodule
bind feat_regs feat_regs_chk #(.AW(AW)) feat_regs_chk_inst (.clock, .resetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .load_valid, .load_addr, .pf_valid,
   .pf_addr, .scale_enable, .scale_locked, .accel_enabled_flag);

// ---- dv/testbench.sv ----
// Self-checking bench for the feature register bank and its prefetchers.
// Assumes the slave alone drives hready and a 125 MHz clock.
`timescale 1ns/1ns
module testbench;
   import feat_pkg::*;
   logic clock = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, load_valid = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, load_addr = 32'h0, hrdata, pf_addr, r, d;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hready, hreadyout, hresp, pf_valid, scale_enable, scale_locked, accel_enabled_flag;
   logic [25:0] ln;
   int errors = 0, num_checks = 0;
   always #4 clock = ~clock;
   assign hready = hreadyout;
   feat_regs feat_regs_inst (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .load_valid, .load_addr, .pf_valid, .pf_addr,
      .scale_enable, .scale_locked, .accel_enabled_flag);
   // ==========================================================
   // Bus and load tasks.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic edge_rdy;
      int n;
      n = 0;
      @(posedge clock);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            errors++;
            print_verdict;
         end
         @(posedge clock);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= {24'h0, a};
      edge_rdy;
      htrans <= 2'h0;
      hwdata <= wd;
      edge_rdy;
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(r, exp);
   endtask
   task automatic ld(input logic [31:0] a, input logic exp);
      load_valid <= 1'b1;
      load_addr <= a;
      @(posedge clock);
      load_valid <= 1'b0;
      #1;
      check({31'h0, pf_valid}, {31'h0, exp});
      if (exp) check(pf_addr, {a[31:6] + 26'h1, 6'h00});
      @(posedge clock);
   endtask
   initial begin
      void'($urandom(73755));
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      rd(OFS_LOW, 32'h0);
      rd(OFS_HIGH, 32'h40);
      rd(OFS_QUERY, 32'h0);
      rd(8'h10, 32'h0);
      for (int m = 0; m < 2; m++) begin
         xfer(1'b1, OFS_HIGH, m ? 32'hFFFF_FFFF : 32'h0);
         rd(OFS_HIGH, m ? 32'hE0 : 32'h0);
         rd(OFS_QUERY, m ? 32'h0 : 32'h2);
         check({31'h0, accel_enabled_flag}, m ? 32'h0 : 32'h1);
         rd(OFS_PF_STATUS, m ? 32'h0 : 32'h3);
         ln = 26'($urandom);
         ld({ln, 6'h04}, 1'b0);
         ld({ln, 6'h10}, 1'b0);
         ld({ln, 6'h3C}, !m);
         ld({ln + 26'h1, 6'h08}, !m);
      end
      repeat (6) begin
         d = $urandom & 32'hFFEF_FFFF;
         xfer(1'b1, OFS_LOW, d);
         rd(OFS_LOW, d & 32'h0001_0000);
      end
      xfer(1'b1, OFS_LOW, 32'h0011_0000);
      xfer(1'b1, OFS_LOW, 32'h0);
      rd(OFS_LOW, 32'h0011_0000);
      check({30'h0, scale_locked, scale_enable}, 32'h3);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      rd(OFS_LOW, 32'h0);
      check({30'h0, scale_locked, scale_enable}, 32'h0);
      xfer(1'b1, OFS_LOW, 32'h0001_0000);
      rd(OFS_LOW, 32'h0001_0000);
      print_verdict;
   end
endmodule
